// *** pmic_output_enable_config_regs.sv ***
`timescale 1ns/10ps
`default_nettype none
// Function
// - Enable bit 6 drives pin three low at 0, high impedance at 1.
// - With warm-reset pin enable set, bit 6 has no effect.
// - Enable bit 5 drives output two low at 0; at 1 releases it (open-drain) or drives it high (push-pull); resets 0.
// - Enable bit 4 drives output one low at 0, releases at 1; resets 1.
// - With pin one input mode set, bits 5 and 4 have no effect.
// - Bits 3 and 2 enable switches three and two; both reset disabled.
// - Bits 1, 0 enable switch one and regulator; reset on; sequencer updates.
// - Config bit 7 picks button reset hold: 0 is 8 s, 1 is 15 s.
// - Config bit 6 picks output two buffer: open-drain or push-pull.
// - Config bit 5 makes pin one an input that steers output two.
// - Config bits 4-3 pick power-good delay 10, 20, 50 or 150 ms.
// - Delay applies to rising power-good only; falling passes at once.
// - Config bit 2 picks tight limits with overvoltage monitoring.
// - With warm-reset pin enable set, pin three is a warm-reset input.
module pmic_output_enable_config_regs
  import pmic_cfg_pkg::*;
#(
  parameter logic [7:0] UNLOCK_CODE = 8'h5A, // Arbitrary unlock value.
  parameter longint PG_DLY0_CYC = PG_DELAY_0_CYC,
  parameter longint PG_DLY1_CYC = PG_DELAY_1_CYC,
  parameter longint PG_DLY2_CYC = PG_DELAY_2_CYC,
  parameter longint PG_DLY3_CYC = PG_DELAY_3_CYC,
  parameter longint PB_SHORT_CYC = PB_RESET_SHORT_CYC,
  parameter longint PB_LONG_CYC = PB_RESET_LONG_CYC
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Register port from the serial control bus back end
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  output logic reg_wr_refused,
  // Power sequencer updates of switch one and the regulator
  input wire logic seq_update,
  input wire logic seq_switch_one,
  input wire logic seq_linear_reg,
  // Warm-reset pin enable from the neighbouring configuration register
  input wire logic warm_reset_pin_enable,
  // Switch and regulator enables
  output logic switch_three_enable,
  output logic switch_two_enable,
  output logic switch_one_enable,
  output logic linear_reg_enable,
  // Pin three: general-purpose open-drain output or warm-reset input
  input wire logic gp_pin_three_in,
  output logic gp_pin_three_out,
  output logic gp_pin_three_oe,
  output logic warm_reset_req,
  // Pin one: open-drain output or control input
  input wire logic gp_pin_one_in,
  output logic gp_pin_one_out,
  output logic gp_pin_one_oe,
  // Output two: open-drain or push-pull from the switch one input supply
  output logic gp_out_two_out,
  output logic gp_out_two_oe,
  // Supervisor and timing
  input wire logic power_good_raw,
  input wire logic push_button_pressed,
  output logic power_good,
  output logic push_button_reset,
  output logic supervisor_tight,
  output logic [1:0] undervoltage_lockout_level
);

  initial begin
    if (PG_DLY0_CYC < 1 || PG_DLY3_CYC >= (64'd1 << TIMER_W)) begin
      $error("power-good delay counts out of range");
    end
    if (PB_SHORT_CYC < 1 || PB_LONG_CYC >= (64'd1 << TIMER_W)) begin
      $error("button hold counts out of range");
    end
  end

  logic [7:0] enable_q;
  logic [7:0] config_q;
  logic unlocked_q;
  logic [7:0] rdata_d;
  logic wr_enable;
  logic wr_config;
  logic protected_hit;
  logic [TIMER_W-1:0] pg_delay_cyc;
  logic [TIMER_W-1:0] pb_hold_cyc;
  logic out_two_level;
  logic pg_filtered;
  logic pb_fire;

  // Two-flop synchronisers for every input that comes from a pin or comparator.
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic pin_three_s;
  logic pin_one_s;
  logic pg_raw_s;
  logic pb_s;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
    end else begin
      sync1_q <= {push_button_pressed, power_good_raw, gp_pin_one_in, gp_pin_three_in};
      sync2_q <= sync1_q;
    end
  end

  assign pin_three_s = sync2_q[0];
  assign pin_one_s = sync2_q[1];
  assign pg_raw_s = sync2_q[2];
  assign pb_s = sync2_q[3];

  // Address decode; a protected write counts only after an unlock.
  assign protected_hit = (reg_addr == OFS_SWITCH_LDO_GPO_ENABLE) ||
                         (reg_addr == OFS_PIN_TIMING_SUPERVISOR_CONFIG);
  assign wr_enable = reg_wr && unlocked_q && (reg_addr == OFS_SWITCH_LDO_GPO_ENABLE);
  assign wr_config = reg_wr && unlocked_q &&
                     (reg_addr == OFS_PIN_TIMING_SUPERVISOR_CONFIG);

  // The unlock lasts for exactly one following write, whatever its address,
  // so a stray write cannot leave the protected registers open.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      unlocked_q <= 1'b0;
    end else if (reg_wr) begin
      unlocked_q <= (reg_addr == OFS_UNLOCK_CODE) && (reg_wdata == UNLOCK_CODE);
    end
  end

  // Flags a protected write that arrived without an unlock.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      reg_wr_refused <= 1'b0;
    end else begin
      reg_wr_refused <= reg_wr && protected_hit && !unlocked_q;
    end
  end

  // Enable register. The sequencer overrides a bus write to bits 1 and 0
  // in the same cycle, since power sequencing must not be undone by software.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      enable_q <= RST_SWITCH_LDO_GPO_ENABLE;
    end else begin
      if (wr_enable) begin
        enable_q[6:0] <= reg_wdata[6:0];
      end
      enable_q[EN_RSVD_BIT] <= 1'b0;
      if (seq_update) begin
        enable_q[EN_SWITCH_ONE_BIT] <= seq_switch_one;
        enable_q[EN_LINEAR_REG_BIT] <= seq_linear_reg;
      end
    end
  end

  // Configuration register; every field is plain read/write.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      config_q <= RST_PIN_TIMING_SUPERVISOR_CONFIG;
    end else if (wr_config) begin
      config_q <= reg_wdata;
    end
  end

  // Read mux; the unlock register always reads back zero.
  always_comb begin
    unique case (reg_addr)
      OFS_SWITCH_LDO_GPO_ENABLE: rdata_d = enable_q;
      OFS_PIN_TIMING_SUPERVISOR_CONFIG: rdata_d = config_q;
      default: rdata_d = RD_UNMAPPED;
    endcase
  end

  // Read data is registered; it appears one cycle after the read strobe.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= rdata_d;
      end
    end
  end

  // Switch and regulator enables follow their bits directly.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      switch_three_enable <= 1'b0;
      switch_two_enable <= 1'b0;
      switch_one_enable <= 1'b1;
      linear_reg_enable <= 1'b1;
    end else begin
      switch_three_enable <= enable_q[EN_SWITCH_THREE_BIT];
      switch_two_enable <= enable_q[EN_SWITCH_TWO_BIT];
      switch_one_enable <= enable_q[EN_SWITCH_ONE_BIT];
      linear_reg_enable <= enable_q[EN_LINEAR_REG_BIT];
    end
  end

  // Pin three: released while it serves as the warm-reset input, where its
  // synchronised level becomes the reset request to the first two bucks.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      gp_pin_three_out <= 1'b0;
      gp_pin_three_oe <= 1'b1;
      warm_reset_req <= 1'b0;
    end else begin
      gp_pin_three_out <= 1'b0;
      if (warm_reset_pin_enable) begin
        gp_pin_three_oe <= 1'b0;
        warm_reset_req <= pin_three_s;
      end else begin
        gp_pin_three_oe <= !enable_q[EN_GP_PIN_THREE_BIT];
        warm_reset_req <= 1'b0;
      end
    end
  end

  // Output two level: its own bit, or the pin one input in input mode.
  assign out_two_level = config_q[CFG_PIN_ONE_MODE_BIT] ? pin_one_s :
                         enable_q[EN_GP_OUT_TWO_BIT];

  // Pin one and output two drivers. Push-pull drives both levels; its high
  // rail is the switch one input supply, which the pad handles, not this logic.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      gp_pin_one_out <= 1'b0;
      gp_pin_one_oe <= 1'b0;
      gp_out_two_out <= 1'b0;
      gp_out_two_oe <= 1'b1;
    end else begin
      gp_pin_one_out <= 1'b0;
      if (config_q[CFG_PIN_ONE_MODE_BIT]) begin
        gp_pin_one_oe <= 1'b0;
      end else begin
        gp_pin_one_oe <= !enable_q[EN_GP_OUT_ONE_BIT];
      end
      if (config_q[CFG_OUT_TWO_BUFFER_BIT]) begin
        gp_out_two_out <= out_two_level;
        gp_out_two_oe <= 1'b1;
      end else begin
        gp_out_two_out <= 1'b0;
        gp_out_two_oe <= !out_two_level;
      end
    end
  end

  // Power-good delay selection.
  always_comb begin
    unique case (pg_delay_sel_t'(config_q[CFG_PG_DELAY_HI:CFG_PG_DELAY_LO]))
      PGD_10MS: pg_delay_cyc = TIMER_W'(PG_DLY0_CYC);
      PGD_20MS: pg_delay_cyc = TIMER_W'(PG_DLY1_CYC);
      PGD_50MS: pg_delay_cyc = TIMER_W'(PG_DLY2_CYC);
      PGD_150MS: pg_delay_cyc = TIMER_W'(PG_DLY3_CYC);
    endcase
  end

  // Button hold time selection.
  assign pb_hold_cyc = config_q[CFG_PB_RESET_TIME_BIT] ? TIMER_W'(PB_LONG_CYC) :
                       TIMER_W'(PB_SHORT_CYC);

  // Rising power-good waits out the delay; falling passes immediately.
  pg_delay_filter #(
    .CNT_W(TIMER_W)
  ) u_pg_delay (
    .ref_clk(ref_clk),
    .rst(rst),
    .pg_in(pg_raw_s),
    .delay_cycles(pg_delay_cyc),
    .pg_out(pg_filtered)
  );

  hold_reset_timer #(
    .CNT_W(TIMER_W)
  ) u_pb_timer (
    .ref_clk(ref_clk),
    .rst(rst),
    .pressed(pb_s),
    .hold_cycles(pb_hold_cyc),
    .fire(pb_fire)
  );

  // Timing and supervisor outputs. The filtered power-good is reregistered
  // so every top output sits on a flop of this module.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      power_good <= 1'b0;
      push_button_reset <= 1'b0;
      supervisor_tight <= 1'b0;
      undervoltage_lockout_level <= 2'h0;
    end else begin
      power_good <= pg_filtered;
      push_button_reset <= pb_fire;
      supervisor_tight <= config_q[CFG_SUPERVISOR_TIGHT_BIT];
      undervoltage_lockout_level <= config_q[CFG_UNDERVOLTAGE_LOCKOUT_LEVEL_HI:CFG_UNDERVOLTAGE_LOCKOUT_LEVEL_LO];
    end
  end

endmodule // pmic_output_enable_config_regs
`default_nettype wire

// *** pmic_cfg_pkg.sv ***
package pmic_cfg_pkg;

  // Register offsets on the serial control bus.
  localparam logic [7:0] OFS_UNLOCK_CODE = 8'h10;
  localparam logic [7:0] OFS_SWITCH_LDO_GPO_ENABLE = 8'h12;
  localparam logic [7:0] OFS_PIN_TIMING_SUPERVISOR_CONFIG = 8'h13;

  // Values after reset.
  localparam logic [7:0] RST_SWITCH_LDO_GPO_ENABLE = 8'h13;
  localparam logic [7:0] RST_PIN_TIMING_SUPERVISOR_CONFIG = 8'h00;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;

  // Field positions of the enable register.
  localparam int EN_RSVD_BIT = 7;
  localparam int EN_GP_PIN_THREE_BIT = 6;
  localparam int EN_GP_OUT_TWO_BIT = 5;
  localparam int EN_GP_OUT_ONE_BIT = 4;
  localparam int EN_SWITCH_THREE_BIT = 3;
  localparam int EN_SWITCH_TWO_BIT = 2;
  localparam int EN_SWITCH_ONE_BIT = 1;
  localparam int EN_LINEAR_REG_BIT = 0;

  // Field positions of the configuration register.
  localparam int CFG_PB_RESET_TIME_BIT = 7;
  localparam int CFG_OUT_TWO_BUFFER_BIT = 6;
  localparam int CFG_PIN_ONE_MODE_BIT = 5;
  localparam int CFG_PG_DELAY_HI = 4;
  localparam int CFG_PG_DELAY_LO = 3;
  localparam int CFG_SUPERVISOR_TIGHT_BIT = 2;
  localparam int CFG_UNDERVOLTAGE_LOCKOUT_LEVEL_HI = 1;
  localparam int CFG_UNDERVOLTAGE_LOCKOUT_LEVEL_LO = 0;

  // Power-good delay codes.
  typedef enum logic [1:0] {
    PGD_10MS = 2'h0,
    PGD_20MS = 2'h1,
    PGD_50MS = 2'h2,
    PGD_150MS = 2'h3
  } pg_delay_sel_t;

  // Clock rate and documented times.
  localparam longint CLK_HZ = 50_000_000;
  localparam longint PG_DELAY_0_MS = 10;
  localparam longint PG_DELAY_1_MS = 20;
  localparam longint PG_DELAY_2_MS = 50;
  localparam longint PG_DELAY_3_MS = 150;
  localparam longint PB_RESET_SHORT_S = 8;
  localparam longint PB_RESET_LONG_S = 15;

  // Cycle counts derived from the times; all are least times, exact here.
  localparam longint PG_DELAY_0_CYC = (PG_DELAY_0_MS * CLK_HZ + 999) / 1000;
  localparam longint PG_DELAY_1_CYC = (PG_DELAY_1_MS * CLK_HZ + 999) / 1000;
  localparam longint PG_DELAY_2_CYC = (PG_DELAY_2_MS * CLK_HZ + 999) / 1000;
  localparam longint PG_DELAY_3_CYC = (PG_DELAY_3_MS * CLK_HZ + 999) / 1000;
  localparam longint PB_RESET_SHORT_CYC = PB_RESET_SHORT_S * CLK_HZ;
  localparam longint PB_RESET_LONG_CYC = PB_RESET_LONG_S * CLK_HZ;

  // Width of the timers; 15 s at 50 MHz needs 30 bits.
  localparam int TIMER_W = 30;

endpackage

// *** pg_delay_filter.sv ***
`timescale 1ns/10ps
`default_nettype none
// Delays the rising edge of power-good; the falling edge passes at once.
module pg_delay_filter #(
  parameter int CNT_W = 30
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Synchronised raw power-good and selected delay
  input wire logic pg_in,
  input wire logic [CNT_W-1:0] delay_cycles,
  // Filtered power-good
  output logic pg_out
);

  logic [CNT_W-1:0] cnt_q;

  initial begin
    if (CNT_W < 2) $error("pg_delay_filter: CNT_W too small");
  end

  // A low input clears at once so faults are never hidden behind the delay.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
      pg_out <= 1'b0;
    end else if (!pg_in) begin
      cnt_q <= '0;
      pg_out <= 1'b0;
    end else if (!pg_out) begin
      if (cnt_q + 1'b1 >= delay_cycles) begin
        pg_out <= 1'b1;
      end
      cnt_q <= cnt_q + 1'b1;
    end
  end

endmodule // pg_delay_filter
`default_nettype wire

// *** hold_reset_timer.sv ***
`timescale 1ns/10ps
`default_nettype none
// Fires one pulse when a button has been held for the selected time.
module hold_reset_timer #(
  parameter int CNT_W = 30
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Synchronised press level and selected hold time
  input wire logic pressed,
  input wire logic [CNT_W-1:0] hold_cycles,
  // One-cycle reset request
  output logic fire
);

  logic [CNT_W-1:0] cnt_q;
  logic done_q;

  initial begin
    if (CNT_W < 2) $error("hold_reset_timer: CNT_W too small");
  end

  // Only one pulse per press; release rearms the timer.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
      done_q <= 1'b0;
      fire <= 1'b0;
    end else if (!pressed) begin
      cnt_q <= '0;
      done_q <= 1'b0;
      fire <= 1'b0;
    end else begin
      fire <= 1'b0;
      if (!done_q) begin
        cnt_q <= cnt_q + 1'b1;
        if (cnt_q + 1'b1 >= hold_cycles) begin
          done_q <= 1'b1;
          fire <= 1'b1;
        end
      end
    end
  end

endmodule // hold_reset_timer
`default_nettype wire

// *** pmic_regs_chk_sva.sv ***
`timescale 1ns/10ps
`default_nettype none
// Port checks for the enable and configuration registers; sees only the top ports.
module pmic_regs_chk
  import pmic_cfg_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  // Pins and outputs
  input wire logic warm_reset_pin_enable,
  input wire logic gp_pin_three_in,
  input wire logic gp_pin_three_out,
  input wire logic gp_pin_three_oe,
  input wire logic warm_reset_req,
  input wire logic gp_pin_one_out,
  input wire logic switch_three_enable,
  input wire logic power_good_raw,
  input wire logic power_good,
  input wire logic push_button_reset
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  // Reads of the enable register answer next cycle with the reserved bit clear.
  AST_RSVD_READ: assert property (
    reg_rd && reg_addr == OFS_SWITCH_LDO_GPO_ENABLE |=> reg_rvalid && !reg_rdata[7])
    else $error("reserved enable bit read as one");
  // Open-drain pins only ever pull low; the release is done through the enable.
  AST_PINS_LOW: assert property (!gp_pin_three_out && !gp_pin_one_out)
    else $error("open-drain pin driven high");
  AST_PIN3_IGNORED: assert property (warm_reset_pin_enable |=> !gp_pin_three_oe)
    else $error("pin three driven while used as warm-reset input");
  AST_WARM_OFF: assert property (!warm_reset_pin_enable |=> !warm_reset_req)
    else $error("warm reset request without pin enable");
  // Two sync flops and one output flop: the request lags the pin by three samples.
  AST_WARM_FOLLOW: assert property (
    warm_reset_pin_enable [*4] |-> warm_reset_req == $past(gp_pin_three_in, 3))
    else $error("warm reset request does not follow pin three");
  AST_PG_FALL: assert property (!power_good_raw [*5] |-> !power_good)
    else $error("power good fall delayed");
  AST_PG_RISE: assert property (
    $rose(power_good) |-> power_good_raw && $past(power_good_raw, 10))
    else $error("power good rose before shortest delay");
  AST_PB_PULSE: assert property (push_button_reset |=> !push_button_reset)
    else $error("button reset longer than one cycle");
  // The switch three enable only moves shortly after a bus write.
  AST_SW3_CAUSE: assert property (
    $changed(switch_three_enable) |-> $past(reg_wr, 1) || $past(reg_wr, 2) || $past(reg_wr, 3))
    else $error("switch three enable changed without a write");

  // Main scenarios seen.
  COV_PG_RISE: cover property ($rose(power_good));
  COV_PB_FIRE: cover property (push_button_reset);
  COV_WARM_REQ: cover property (warm_reset_req);
endmodule // pmic_regs_chk

bind pmic_output_enable_config_regs pmic_regs_chk u_chk (.ref_clk, .rst, .reg_addr, .reg_rd,
  .reg_wr, .reg_rdata, .reg_rvalid, .warm_reset_pin_enable, .gp_pin_three_in, .gp_pin_three_out,
  .gp_pin_three_oe, .warm_reset_req, .gp_pin_one_out, .switch_three_enable, .power_good_raw,
  .power_good, .push_button_reset);
`default_nettype wire

// *** pmic_host_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// Bus host: one-cycle strobes, an unlock written just before each protected write.
module pmic_host_model
  import pmic_cfg_pkg::*;
#(
  parameter logic [7:0] UNLOCK = 8'h5A
) (
  // Clock
  input wire logic ref_clk,
  // Register port drive
  output logic [7:0] reg_addr = 8'h00,
  output logic [7:0] reg_wdata = 8'hFF,
  output logic reg_wr = 1'b0,
  output logic reg_rd = 1'b0,
  // Read answer
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid
);
  // Data is inverted once released so a stale value never passes for live data.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask

  // Protected write: the unlock must be the write right before it.
  task automatic pwr(input logic [7:0] a, input logic [7:0] d);
    wr(OFS_UNLOCK_CODE, UNLOCK);
    wr(a, d);
  endtask

  // Answer is taken once the edge that sampled the strobe has landed.
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
    v = reg_rvalid;
  endtask
endmodule // pmic_host_model
`default_nettype wire

// *** test_pmic_output_enable_config_regs.sv ***
`timescale 1ns/10ps
`default_nettype none
// Self-checking bench with an integer model of both registers.
module test_pmic_output_enable_config_regs;
  import pmic_cfg_pkg::*;
  localparam logic [7:0] UNLOCK = 8'hC3; // Arbitrary unlock value.
  localparam int PGD [4] = '{10, 20, 50, 150};
  logic ref_clk = 1'b0, rst = 1'b1;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic reg_wr, reg_rd, reg_rvalid, reg_wr_refused;
  logic seq_update = 1'b0, seq_switch_one = 1'b0, seq_linear_reg = 1'b0;
  logic warm_reset_pin_enable = 1'b0, power_good_raw = 1'b0, push_button_pressed = 1'b0;
  logic switch_three_enable, switch_two_enable, switch_one_enable, linear_reg_enable;
  logic gp_pin_three_out, gp_pin_three_oe, warm_reset_req, gp_pin_one_out, gp_pin_one_oe;
  logic gp_out_two_out, gp_out_two_oe, power_good, push_button_reset, supervisor_tight;
  logic [1:0] undervoltage_lockout_level;
  logic p3_ext = 1'b1, p1_ext = 1'b1;
  logic [15:0] seed = 16'h2E1C; // Starting state 11804.
  int en_m = 'h13, cfg_m = 0, num_errors = 0, n_checks = 0;
  wire gp_pin_three_in, gp_pin_one_in;

  // Pins have pull-ups: a driven pin reads low, a released one follows the outside level.
  assign gp_pin_three_in = gp_pin_three_oe ? gp_pin_three_out : p3_ext;
  assign gp_pin_one_in = gp_pin_one_oe ? gp_pin_one_out : p1_ext;

  pmic_output_enable_config_regs #(.UNLOCK_CODE(UNLOCK), .PG_DLY0_CYC(PGD[0]),
    .PG_DLY1_CYC(PGD[1]), .PG_DLY2_CYC(PGD[2]), .PG_DLY3_CYC(PGD[3]), .PB_SHORT_CYC(100),
    .PB_LONG_CYC(200)
  ) u_pmic_output_enable_config_regs (
    .ref_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .reg_rvalid,
    .reg_wr_refused, .seq_update, .seq_switch_one, .seq_linear_reg, .warm_reset_pin_enable,
    .switch_three_enable, .switch_two_enable, .switch_one_enable, .linear_reg_enable,
    .gp_pin_three_in, .gp_pin_three_out, .gp_pin_three_oe, .warm_reset_req, .gp_pin_one_in,
    .gp_pin_one_out, .gp_pin_one_oe, .gp_out_two_out, .gp_out_two_oe, .power_good_raw,
    .push_button_pressed, .power_good, .push_button_reset, .supervisor_tight,
    .undervoltage_lockout_level);

  pmic_host_model #(.UNLOCK(UNLOCK)) u_pmic_host_model (.ref_clk, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .reg_rvalid);

  // Free-running 50 MHz clock.
  initial begin
    forever #10 ref_clk = ~ref_clk;
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic test_done;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk_reg(input logic [7:0] a, input int exp);
    logic [7:0] d;
    logic v;
    u_pmic_host_model.rd(a, d, v);
    check("rvalid", v, 1'b1);
    check("rdata", d, exp[7:0]);
  endtask

  // Pins take three edges to settle, so outputs are compared after four.
  task automatic chk_outs;
    logic lvl;
    repeat (4) @(posedge ref_clk);
    #1;
    lvl = cfg_m[5] ? p1_ext : en_m[5];
    check("enables", {switch_three_enable, switch_two_enable, switch_one_enable,
      linear_reg_enable}, en_m[3:0]);
    check("pin3 oe", gp_pin_three_oe, !warm_reset_pin_enable && !en_m[6]);
    check("warm req", warm_reset_req, warm_reset_pin_enable && p3_ext);
    check("pin1 oe", gp_pin_one_oe, !cfg_m[5] && !en_m[4]);
    check("out2", {gp_out_two_oe, gp_out_two_out},
      cfg_m[6] ? {1'b1, lvl} : {!lvl, 1'b0});
    check("supervisor", {supervisor_tight, undervoltage_lockout_level}, cfg_m[2:0]);
  endtask

  // Counts edges until a timed output rises; running out of the bound ends the run.
  task automatic wait_hi(input logic which, input int lo);
    int n;
    n = 0;
    while (n < lo + 8 && (which ? push_button_reset : power_good) !== 1'b1) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    check("delay", n >= lo && n <= lo + 4, 1'b1);
    if (n >= lo + 8) test_done;
  endtask

  initial begin
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    chk_reg(OFS_SWITCH_LDO_GPO_ENABLE, RST_SWITCH_LDO_GPO_ENABLE);
    chk_reg(OFS_PIN_TIMING_SUPERVISOR_CONFIG, 0);
    chk_reg(OFS_UNLOCK_CODE, 0);
    chk_reg(8'h7E, 0);
    chk_outs;
    // A protected write with no unlock is thrown away.
    u_pmic_host_model.wr(OFS_SWITCH_LDO_GPO_ENABLE, 8'h00);
    #1;
    check("refused", reg_wr_refused, 1'b1);
    // A wrong unlock value leaves both registers closed.
    u_pmic_host_model.wr(OFS_UNLOCK_CODE, ~UNLOCK);
    u_pmic_host_model.wr(OFS_SWITCH_LDO_GPO_ENABLE, 8'h00);
    #1;
    check("refused", reg_wr_refused, 1'b1);
    chk_reg(OFS_SWITCH_LDO_GPO_ENABLE, en_m);
    // Random enables, modes and pin levels.
    for (int i = 0; i < 12; i++) begin
      seed = lfsr(seed);
      @(posedge ref_clk);
      warm_reset_pin_enable <= seed[8];
      p1_ext <= seed[9];
      p3_ext <= seed[10];
      u_pmic_host_model.pwr(OFS_SWITCH_LDO_GPO_ENABLE, seed[7:0]);
      u_pmic_host_model.pwr(OFS_PIN_TIMING_SUPERVISOR_CONFIG, seed[15:8]);
      en_m = seed[6:0];
      cfg_m = seed[15:8];
      chk_reg(OFS_SWITCH_LDO_GPO_ENABLE, en_m);
      chk_reg(OFS_PIN_TIMING_SUPERVISOR_CONFIG, cfg_m);
      chk_outs;
    end
    // The sequencer overrides switch one and the regulator.
    @(posedge ref_clk);
    seq_update <= 1'b1;
    seq_switch_one <= !en_m[1];
    seq_linear_reg <= !en_m[0];
    @(posedge ref_clk);
    seq_update <= 1'b0;
    en_m[1:0] = ~en_m[1:0];
    chk_outs;
    // Every power-good delay code; the fall is never delayed.
    for (int c = 0; c < 4; c++) begin
      u_pmic_host_model.pwr(OFS_PIN_TIMING_SUPERVISOR_CONFIG, 8'(c << 3));
      @(posedge ref_clk);
      power_good_raw <= 1'b1;
      wait_hi(1'b0, PGD[c]);
      @(posedge ref_clk);
      power_good_raw <= 1'b0;
      repeat (5) @(posedge ref_clk);
      #1;
      check("pg fall", power_good, 1'b0);
    end
    // Both button hold times.
    for (int b = 0; b < 2; b++) begin
      u_pmic_host_model.pwr(OFS_PIN_TIMING_SUPERVISOR_CONFIG, 8'(b << 7));
      @(posedge ref_clk);
      push_button_pressed <= 1'b1;
      wait_hi(1'b1, b ? 200 : 100);
      @(posedge ref_clk);
      push_button_pressed <= 1'b0;
      repeat (4) @(posedge ref_clk);
    end
    // A second reset restores the documented values. The warm-reset pin enable
    // lives in a neighbouring register that resets to zero along with these.
    rst <= 1'b1;
    warm_reset_pin_enable <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    en_m = 'h13;
    cfg_m = 0;
    chk_reg(OFS_SWITCH_LDO_GPO_ENABLE, RST_SWITCH_LDO_GPO_ENABLE);
    chk_reg(OFS_PIN_TIMING_SUPERVISOR_CONFIG, 0);
    chk_outs;
    test_done;
  end
endmodule // test_pmic_output_enable_config_regs
`default_nettype wire
